// *** core/idu_addressing_unit.sv ***
// Summary of operation
// RQ1: Plain port addresses memory at the pointer and leaves the pointer unchanged.
// RQ2: Post-increment port addresses memory at the pointer, then adds one to it.
// RQ3: Post-decrement port addresses memory at the pointer, then subtracts one.
// RQ4: Pre-increment port adds one to the pointer, then addresses the new value.
// RQ5: Unimplemented upper bits of pointer high bytes and bank select read zero.
// RQ6: Offset port addresses pointer plus signed working value, pointer unchanged.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module idu_addressing_unit
	import idu_pkg::*;
#(
	parameter int NUM_PTR = IDU_NUM_PTR
)
(
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic [IDU_BUS_AW-1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	output logic [IDU_PTR_W-1:0] DMEM_ADDR_OUT,
	output logic DMEM_RD_OUT,
	output logic DMEM_WR_OUT,
	output logic [IDU_DATA_W-1:0] DMEM_WDATA_OUT,
	input wire logic [IDU_DATA_W-1:0] DMEM_RDATA_IN
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// Address decode has room for at most three pointer groups
	if (NUM_PTR < 1 || NUM_PTR > IDU_NUM_PTR)
	begin : g_bad_num_ptr
		$error("NUM_PTR must lie between 1 and 3");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	idu_state_t state_reg;
	idu_state_t state_next;
	logic [IDU_PTR_W-1:0] ptr_reg [NUM_PTR];
	logic [IDU_DATA_W-1:0] working_reg;
	logic [IDU_BANK_W-1:0] bank_reg;
	idu_kind_t op_kind_reg;
	logic [1:0] op_sel_reg;
	logic [IDU_PTR_W-1:0] op_base_reg;
	logic [31:0] readdata_reg;

	// Request decode, straight from the bus
	logic req;
	idu_kind_t req_kind;
	logic [1:0] req_sel;
	logic req_sel_ok;
	logic [IDU_PTR_W-1:0] cur_ptr;
	logic [IDU_PTR_W-1:0] mem_addr_next;
	logic [IDU_PTR_W-1:0] ptr_after;
	logic [IDU_PTR_W-1:0] w_offset;
	logic port_start;
	logic [31:0] reg_rdata;

	assign req = AVS_READ_IN || AVS_WRITE_IN;
	assign req_sel = idu_decode_sel(AVS_ADDRESS_IN);
	assign req_sel_ok = 32'(req_sel) < NUM_PTR;
	// Pointer groups beyond NUM_PTR act as unmapped space
	assign req_kind = (idu_is_port(idu_decode_kind(AVS_ADDRESS_IN))
		|| idu_decode_kind(AVS_ADDRESS_IN) == KIND_PTR_LOW
		|| idu_decode_kind(AVS_ADDRESS_IN) == KIND_PTR_HIGH) && !req_sel_ok
		? KIND_NONE : idu_decode_kind(AVS_ADDRESS_IN);
	assign cur_ptr = req_sel_ok ? ptr_reg[req_sel] : IDU_PTR_RESET;
	// Working value taken as a signed byte
	assign w_offset = {{(IDU_PTR_W-IDU_DATA_W){working_reg[IDU_DATA_W-1]}}, working_reg};
	assign port_start = (state_reg == ST_IDLE) && req && idu_is_port(req_kind);

	// ****************************************************************
	// Address and pointer arithmetic
	// ****************************************************************
	// Effective address and new pointer value of a port access
	always_comb
	begin
		mem_addr_next = cur_ptr;
		ptr_after = cur_ptr;
		unique case (req_kind)
			// RQ1: pointer as address
			KIND_PLAIN:
			begin
				mem_addr_next = cur_ptr;
				ptr_after = cur_ptr;
			end
			// RQ2: old address, then plus one
			KIND_POST_INCREMENT_PORT:
			begin
				mem_addr_next = cur_ptr;
				ptr_after = cur_ptr + 12'h001;
			end
			// RQ3: old address, then minus one
			KIND_POST_DECREMENT_PORT:
			begin
				mem_addr_next = cur_ptr;
				ptr_after = cur_ptr - 12'h001;
			end
			// RQ4: plus one before use
			KIND_PRE_INCREMENT_PORT:
			begin
				mem_addr_next = cur_ptr + 12'h001;
				ptr_after = cur_ptr + 12'h001;
			end
			// RQ6: signed working offset
			KIND_OFFSET:
			begin
				mem_addr_next = cur_ptr + w_offset;
				ptr_after = cur_ptr;
			end
			default:
			begin
				mem_addr_next = cur_ptr;
				ptr_after = cur_ptr;
			end
		endcase
	end

	// Read value of a plain register
	always_comb
	begin
		reg_rdata = 32'h0000_0000;
		unique case (req_kind)
			KIND_PTR_LOW: reg_rdata[IDU_DATA_W-1:0] = cur_ptr[IDU_DATA_W-1:0];
			// RQ5: upper nibble reads zero
			KIND_PTR_HIGH: reg_rdata[IDU_HIGH_W-1:0] = cur_ptr[IDU_PTR_W-1:IDU_DATA_W];
			KIND_WORKING: reg_rdata[IDU_DATA_W-1:0] = working_reg;
			// RQ5: bank select is four bits
			KIND_BANK: reg_rdata[IDU_BANK_W-1:0] = bank_reg;
			default: reg_rdata = 32'h0000_0000;
		endcase
	end

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	// Register accesses answer after one wait cycle, port accesses after three
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (port_start)
					state_next = ST_ISSUE;
				else if (req)
					state_next = ST_DONE;
			end
			ST_ISSUE: state_next = ST_CAPTURE;
			ST_CAPTURE: state_next = ST_DONE;
			ST_DONE: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Waitrequest drops only in the answer cycle
	assign AVS_WAITREQUEST_OUT = !(state_reg == ST_DONE);

	// Operation record, held for the whole access
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			op_kind_reg <= KIND_NONE;
			op_sel_reg <= 2'h0;
			op_base_reg <= IDU_PTR_RESET;
		end
		else if (state_reg == ST_IDLE && req)
		begin
			op_kind_reg <= req_kind;
			op_sel_reg <= req_sel;
			op_base_reg <= cur_ptr;
		end
	end

	// ****************************************************************
	// Pointers, working and bank registers
	// ****************************************************************
	// Side effects of a port land at the issue edge; bus writes at the answer edge
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			for (int i = 0; i < NUM_PTR; i++)
				ptr_reg[i] <= IDU_PTR_RESET;
		end
		else if (port_start)
			ptr_reg[req_sel] <= ptr_after;
		else if (state_reg == ST_DONE && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0])
		begin
			if (op_kind_reg == KIND_PTR_LOW)
				ptr_reg[op_sel_reg][IDU_DATA_W-1:0] <= AVS_WRITEDATA_IN[IDU_DATA_W-1:0];
			// RQ5: only low nibble kept
			else if (op_kind_reg == KIND_PTR_HIGH)
				ptr_reg[op_sel_reg][IDU_PTR_W-1:IDU_DATA_W] <= AVS_WRITEDATA_IN[IDU_HIGH_W-1:0];
		end
	end

	// Working register steers the offset port
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			working_reg <= IDU_WORKING_RESET;
		else if (state_reg == ST_DONE && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0]
			&& op_kind_reg == KIND_WORKING)
			working_reg <= AVS_WRITEDATA_IN[IDU_DATA_W-1:0];
	end

	// Bank select, four bits kept
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			bank_reg <= IDU_BANK_RESET;
		else if (state_reg == ST_DONE && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0]
			&& op_kind_reg == KIND_BANK)
			bank_reg <= AVS_WRITEDATA_IN[IDU_BANK_W-1:0];
	end

	// ****************************************************************
	// Data memory side
	// ****************************************************************
	// One-cycle strobes; memory answers reads on the following edge
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			DMEM_ADDR_OUT <= IDU_PTR_RESET;
			DMEM_RD_OUT <= 1'b0;
			DMEM_WR_OUT <= 1'b0;
			DMEM_WDATA_OUT <= 8'h00;
		end
		else
		begin
			DMEM_RD_OUT <= port_start && AVS_READ_IN;
			// A write with lane 0 off still walks the pointer but stores nothing
			DMEM_WR_OUT <= port_start && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
			if (port_start)
			begin
				DMEM_ADDR_OUT <= mem_addr_next;
				DMEM_WDATA_OUT <= AVS_WRITEDATA_IN[IDU_DATA_W-1:0];
			end
		end
	end

	// Read data, zero above the byte
	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
			readdata_reg <= 32'h0000_0000;
		else if (state_reg == ST_IDLE && req && !port_start)
			readdata_reg <= reg_rdata;
		else if (state_reg == ST_CAPTURE)
			readdata_reg <= {24'h00_0000, DMEM_RDATA_IN};
	end

	assign AVS_READDATA_OUT = readdata_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (SRST_IN);

	logic [IDU_PTR_W-1:0] op_ptr_now;
	assign op_ptr_now = ptr_reg[op_sel_reg];

	// RQ1: plain address check
	a_plain_addr_hold: assert property ( // RQ1
		state_reg == ST_ISSUE && op_kind_reg == KIND_PLAIN
		|-> DMEM_ADDR_OUT == op_base_reg && op_ptr_now == op_base_reg)
		else $error("plain port moved pointer or used wrong address");

	// RQ2: post-increment check
	a_post_increment_port_step: assert property ( // RQ2
		state_reg == ST_ISSUE && op_kind_reg == KIND_POST_INCREMENT_PORT
		|-> DMEM_ADDR_OUT == op_base_reg && op_ptr_now == op_base_reg + 12'h001)
		else $error("post-increment address or pointer wrong");

	// RQ3: post-decrement check
	a_post_decrement_port_step: assert property ( // RQ3
		state_reg == ST_ISSUE && op_kind_reg == KIND_POST_DECREMENT_PORT
		|-> DMEM_ADDR_OUT == op_base_reg && op_ptr_now == op_base_reg - 12'h001)
		else $error("post-decrement address or pointer wrong");

	// RQ4: pre-increment check
	a_pre_increment_port_step: assert property ( // RQ4
		state_reg == ST_ISSUE && op_kind_reg == KIND_PRE_INCREMENT_PORT
		|-> DMEM_ADDR_OUT == op_base_reg + 12'h001 && op_ptr_now == DMEM_ADDR_OUT)
		else $error("pre-increment address or pointer wrong");

	// RQ6: offset port check
	a_offset_addr: assert property ( // RQ6
		state_reg == ST_ISSUE && op_kind_reg == KIND_OFFSET
		|-> DMEM_ADDR_OUT == op_base_reg + w_offset && op_ptr_now == op_base_reg)
		else $error("offset port address wrong or pointer moved");

	// RQ5: zero upper bits on read
	a_high_zero_read: assert property ( // RQ5
		state_reg == ST_DONE && AVS_READ_IN
		&& (op_kind_reg == KIND_PTR_HIGH || op_kind_reg == KIND_BANK)
		|-> AVS_READDATA_OUT[31:IDU_HIGH_W] == 28'h000_0000)
		else $error("unimplemented bits read nonzero");

	// RQ1: port access answers in three cycles
	a_port_answer_time: assert property ( // RQ1
		port_start |-> AVS_WAITREQUEST_OUT [*3] ##1 !AVS_WAITREQUEST_OUT)
		else $error("port access answer timing wrong");

	// RQ2: one strobe per port access
	a_single_strobe: assert property ( // RQ2
		port_start |=> (DMEM_RD_OUT || DMEM_WR_OUT || $past(AVS_WRITE_IN))
		##1 !DMEM_RD_OUT && !DMEM_WR_OUT)
		else $error("memory strobe not a single pulse");

	// RQ1: port write carries data
	a_port_wdata: assert property ( // RQ1
		port_start && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0]
		|=> DMEM_WR_OUT && DMEM_WDATA_OUT == $past(AVS_WRITEDATA_IN[IDU_DATA_W-1:0]))
		else $error("port write strobe or data wrong");

	// RQ2: lane off stores nothing
	a_lane_off_quiet: assert property ( // RQ2
		port_start && AVS_WRITE_IN && !AVS_BYTEENABLE_IN[0]
		|=> !DMEM_WR_OUT && !DMEM_RD_OUT)
		else $error("memory strobe on a masked port write");

	c_post_increment_port_read: cover property (port_start && req_kind == KIND_POST_INCREMENT_PORT && AVS_READ_IN);
	c_offset_negative: cover property (port_start && req_kind == KIND_OFFSET && working_reg[7]);
	c_pre_increment_port_wrap: cover property (port_start && req_kind == KIND_PRE_INCREMENT_PORT && cur_ptr == 12'hFFF);
	c_high_write: cover property (state_reg == ST_DONE && AVS_WRITE_IN && op_kind_reg == KIND_PTR_HIGH);

endmodule

`default_nettype wire

// *** core/idu_pkg.sv ***
// ****************************************************************
// Shared constants and types for the indirect addressing unit
// ****************************************************************
package idu_pkg;

	// Data widths
	localparam int IDU_DATA_W = 8;
	localparam int IDU_PTR_W = 12;
	localparam int IDU_HIGH_W = 4;
	localparam int IDU_BANK_W = 4;
	localparam int IDU_NUM_PTR = 3;
	localparam int IDU_BUS_AW = 8;

	// Register offsets inside one pointer group (byte addresses)
	localparam logic [7:0] IDU_OFF_PLAIN = 8'h00;
	localparam logic [7:0] IDU_OFF_POST_INCREMENT_PORT = 8'h04;
	localparam logic [7:0] IDU_OFF_POST_DECREMENT_PORT = 8'h08;
	localparam logic [7:0] IDU_OFF_PRE_INCREMENT_PORT = 8'h0C;
	localparam logic [7:0] IDU_OFF_OFFSET = 8'h10;
	localparam logic [7:0] IDU_OFF_PTR_LOW = 8'h14;
	localparam logic [7:0] IDU_OFF_PTR_HIGH = 8'h18;
	// Group base of pointer n is n times this stride
	localparam logic [7:0] IDU_GROUP_STRIDE = 8'h20;
	localparam logic [7:0] IDU_GROUP_MASK = 8'h1F;
	// Shared registers
	localparam logic [7:0] IDU_OFF_WORKING = 8'h60;
	localparam logic [7:0] IDU_OFF_BANK = 8'h64;

	// Reset values
	localparam logic [IDU_PTR_W-1:0] IDU_PTR_RESET = 12'h000;
	localparam logic [IDU_DATA_W-1:0] IDU_WORKING_RESET = 8'h00;
	localparam logic [IDU_BANK_W-1:0] IDU_BANK_RESET = 4'h0;

	// Kind of register an address selects
	typedef enum logic [3:0] {
		KIND_PLAIN,
		KIND_POST_INCREMENT_PORT,
		KIND_POST_DECREMENT_PORT,
		KIND_PRE_INCREMENT_PORT,
		KIND_OFFSET,
		KIND_PTR_LOW,
		KIND_PTR_HIGH,
		KIND_WORKING,
		KIND_BANK,
		KIND_NONE
	} idu_kind_t;

	// Access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_CAPTURE,
		ST_DONE
	} idu_state_t;

	// Kind of register at a byte address
	function automatic idu_kind_t idu_decode_kind(input logic [IDU_BUS_AW-1:0] addr);
		logic [7:0] low;
		idu_kind_t kind;
		low = addr & IDU_GROUP_MASK;
		kind = KIND_NONE;
		if (addr == IDU_OFF_WORKING)
			kind = KIND_WORKING;
		else if (addr == IDU_OFF_BANK)
			kind = KIND_BANK;
		else if (addr < IDU_OFF_WORKING)
		begin
			unique case (low)
				IDU_OFF_PLAIN: kind = KIND_PLAIN;
				IDU_OFF_POST_INCREMENT_PORT: kind = KIND_POST_INCREMENT_PORT;
				IDU_OFF_POST_DECREMENT_PORT: kind = KIND_POST_DECREMENT_PORT;
				IDU_OFF_PRE_INCREMENT_PORT: kind = KIND_PRE_INCREMENT_PORT;
				IDU_OFF_OFFSET: kind = KIND_OFFSET;
				IDU_OFF_PTR_LOW: kind = KIND_PTR_LOW;
				IDU_OFF_PTR_HIGH: kind = KIND_PTR_HIGH;
				default: kind = KIND_NONE;
			endcase
		end
		return kind;
	endfunction

	// Pointer index at a byte address
	function automatic logic [1:0] idu_decode_sel(input logic [IDU_BUS_AW-1:0] addr);
		return addr[6:5];
	endfunction

	// True for the five virtual access ports
	function automatic logic idu_is_port(input idu_kind_t kind);
		return (kind == KIND_PLAIN) || (kind == KIND_POST_INCREMENT_PORT) || (kind == KIND_POST_DECREMENT_PORT)
			|| (kind == KIND_PRE_INCREMENT_PORT) || (kind == KIND_OFFSET);
	endfunction

endpackage

// *** verif/idu_dmem_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Data memory seen by the addressing unit
// ****************************************************************
module idu_dmem_model
	import idu_pkg::*;
(
	input wire logic clk_in,
	input wire logic [IDU_PTR_W-1:0] addr_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [IDU_DATA_W-1:0] wdata_in,
	output logic [IDU_DATA_W-1:0] rdata_out
);
	logic [IDU_DATA_W-1:0] mem_arr [0:4095];

	// Known fill so every cell has a predictable value
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem_arr[i] = i[7:0] ^ 8'h5A;
		rdata_out = 8'h00;
	end

	// One-cycle read latency; between reads the bus toggles so stale data never passes
	// Plain always: the fill above also writes these variables
	always @(posedge clk_in)
	begin
		if (wr_in)
			mem_arr[addr_in] <= wdata_in;
		if (rd_in)
			rdata_out <= mem_arr[addr_in];
		else
			rdata_out <= ~rdata_out;
	end
endmodule

`default_nettype wire

// *** verif/tb_indirect_data_addressing_unit.sv ***
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

// ****************************************************************
// Bench for the indirect addressing unit
// ****************************************************************
module tb_indirect_data_addressing_unit;
	import idu_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_wdata = 32'h0;
	logic [3:0] avs_be = 4'h0;
	logic [31:0] avs_rdata;
	logic avs_waitreq;
	logic [IDU_PTR_W-1:0] dm_addr;
	logic dm_rd;
	logic dm_wr;
	logic [7:0] dm_wdata;
	logic [7:0] dm_rdata;
	int n_fail = 0;
	int checks = 0;

	// Clock, 100 MHz
	always #5 clk = ~clk;

	idu_addressing_unit idu_addressing_unit_i (.CLK_IN(clk), .SRST_IN(srst),
		.AVS_ADDRESS_IN(avs_address), .AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write),
		.AVS_WRITEDATA_IN(avs_wdata), .AVS_BYTEENABLE_IN(avs_be),
		.AVS_READDATA_OUT(avs_rdata), .AVS_WAITREQUEST_OUT(avs_waitreq),
		.DMEM_ADDR_OUT(dm_addr), .DMEM_RD_OUT(dm_rd), .DMEM_WR_OUT(dm_wr),
		.DMEM_WDATA_OUT(dm_wdata), .DMEM_RDATA_IN(dm_rdata));

	idu_dmem_model idu_dmem_model_i (.clk_in(clk), .addr_in(dm_addr), .rd_in(dm_rd),
		.wr_in(dm_wr), .wdata_in(dm_wdata), .rdata_out(dm_rdata));

	// Byte address of a register inside pointer group n
	function automatic logic [7:0] grp(input int n, input logic [7:0] off);
		return IDU_GROUP_STRIDE * n[7:0] + off;
	endfunction

	// Avalon access; holds the request until waitrequest is seen low, only the watchdog ends a wait
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_wdata <= {24'h0, d};
		avs_be <= be;
		do
		begin
			@(posedge clk);
		end
		while (avs_waitreq !== 1'b0);
		q = avs_rdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, 4'hF, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] q;
		acc(1'b0, a, 8'h00, 4'hF, q);
		`CHK(q, {24'h0, exp})
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog, far beyond the roughly 160 cycles the tests need
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		complete_run();
	end

	// Main sequence
	initial
	begin
		logic [31:0] q;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		for (int n = 0; n < 3; n++)
		begin
			rdc(grp(n, IDU_OFF_PTR_LOW), 8'h00);
			rdc(grp(n, IDU_OFF_PTR_HIGH), 8'h00);
		end
		rdc(IDU_OFF_WORKING, 8'h00);
		rdc(IDU_OFF_BANK, 8'h00);
		wr(grp(1, IDU_OFF_PTR_HIGH), 8'hFF);
		rdc(grp(1, IDU_OFF_PTR_HIGH), 8'h0F);
		wr(IDU_OFF_BANK, 8'hFF);
		rdc(IDU_OFF_BANK, 8'h0F);
		$display("test reset_and_masks done");
		// Pointer one at the top of memory, then wrap both ways
		wr(grp(1, IDU_OFF_PTR_LOW), 8'hFF);
		wr(grp(1, IDU_OFF_POST_INCREMENT_PORT), 8'hA5);
		`CHK(idu_dmem_model_i.mem_arr[12'hFFF], 8'hA5)
		rdc(grp(1, IDU_OFF_PTR_LOW), 8'h00);
		rdc(grp(1, IDU_OFF_PTR_HIGH), 8'h00);
		wr(grp(1, IDU_OFF_POST_DECREMENT_PORT), 8'h3C);
		`CHK(idu_dmem_model_i.mem_arr[12'h000], 8'h3C)
		rdc(grp(1, IDU_OFF_PTR_LOW), 8'hFF);
		rdc(grp(1, IDU_OFF_PTR_HIGH), 8'h0F);
		rdc(grp(1, IDU_OFF_PRE_INCREMENT_PORT), 8'h3C);
		rdc(grp(1, IDU_OFF_PTR_LOW), 8'h00);
		$display("test stepping_ports done");
		// Pointer two at 0x100
		wr(grp(2, IDU_OFF_PTR_LOW), 8'h00);
		wr(grp(2, IDU_OFF_PTR_HIGH), 8'h01);
		rdc(grp(2, IDU_OFF_PLAIN), 8'h5A);
		wr(grp(2, IDU_OFF_PLAIN), 8'h77);
		`CHK(idu_dmem_model_i.mem_arr[12'h100], 8'h77)
		rdc(grp(2, IDU_OFF_PTR_LOW), 8'h00);
		rdc(grp(2, IDU_OFF_PTR_HIGH), 8'h01);
		$display("test plain_port done");
		// Most negative offset, then a small positive one
		wr(IDU_OFF_WORKING, 8'h80);
		rdc(grp(2, IDU_OFF_OFFSET), 8'hDA);
		wr(IDU_OFF_WORKING, 8'h05);
		wr(grp(2, IDU_OFF_OFFSET), 8'hC3);
		`CHK(idu_dmem_model_i.mem_arr[12'h105], 8'hC3)
		rdc(grp(2, IDU_OFF_PTR_LOW), 8'h00);
		rdc(grp(2, IDU_OFF_PTR_HIGH), 8'h01);
		$display("test offset_port done");
		// Write with byte lane off, then an unmapped place
		acc(1'b1, IDU_OFF_WORKING, 8'hEE, 4'h0, q);
		rdc(IDU_OFF_WORKING, 8'h05);
		wr(8'h70, 8'h99);
		rdc(8'h70, 8'h00);
		// Masked write to a stepping port still walks pointer zero
		acc(1'b1, grp(0, IDU_OFF_POST_INCREMENT_PORT), 8'hEE, 4'h0, q);
		`CHK(idu_dmem_model_i.mem_arr[12'h000], 8'h3C)
		rdc(grp(0, IDU_OFF_PTR_LOW), 8'h01);
		rdc(grp(0, IDU_OFF_POST_DECREMENT_PORT), 8'h5B);
		rdc(grp(0, IDU_OFF_PTR_LOW), 8'h00);
		$display("test refused_access done");
		// Reset in mid-run brings bank and pointers back
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rdc(IDU_OFF_BANK, 8'h00);
		rdc(grp(1, IDU_OFF_PTR_HIGH), 8'h00);
		$display("test mid_reset done");
		complete_run();
	end
endmodule

`default_nettype wire
